/* hw/wcs_pkg.sv */
// Package of register map, field layout and timing constants for the card-sense register bank.
package wcs_pkg;
  // ---------------------------------------------------------------
  // Register indices and byte address width
  // ---------------------------------------------------------------
  localparam logic [7:0] IDX_DETECT_OPTIONS = 8'h3A;
  localparam logic [7:0] IDX_CLK_OUT_DIV    = 8'h3E;
  localparam logic [7:0] IDX_Q_LOWER        = 8'h3F;
  localparam logic [7:0] IDX_Q_UPPER        = 8'h40;
  localparam logic [7:0] IDX_I_LOWER        = 8'h41;
  localparam logic [7:0] IDX_I_LAST         = 8'h42;
  localparam logic [7:0] IDX_Q_LAST         = 8'h43;
  localparam logic [7:0] IDX_DETECT_STATUS  = 8'h48;
  localparam int         ADDR_W             = 10;

  // ---------------------------------------------------------------
  // Field positions and reset values
  // ---------------------------------------------------------------
  localparam int         OPT_TX_FULL_SWING  = 3;
  localparam int         OPT_NOISE_FILTER   = 2;
  localparam int         OPT_Q_UNSETTLED    = 1;
  localparam int         OPT_I_UNSETTLED    = 0;
  localparam int         QRES_SUPPRESS      = 6;
  localparam int         LIMIT_HI_BIT       = 7;
  localparam int         LIMIT_LO_BIT       = 6;
  localparam logic [7:0] RST_DIVIDER        = 8'h08;
  localparam logic [7:0] RST_LIMIT          = 8'h00;
  localparam logic [7:0] RST_OPTIONS        = 8'h00;
  localparam logic [7:0] DIV_MIN            = 8'h08;
  localparam logic [7:0] DIV_MAX            = 8'hFE;

  // ---------------------------------------------------------------
  // Timing: longest sampling time, rounded down to cycles
  // ---------------------------------------------------------------
  localparam int         CLK_PERIOD_PS      = 10000;
  localparam int         SAMPLE_MAX_PS      = 4720000;
  localparam int         SAMPLE_MAX_CYC_RAW = SAMPLE_MAX_PS / CLK_PERIOD_PS;
  localparam int         SAMPLE_MAX_CYC     = (SAMPLE_MAX_CYC_RAW < 1) ? 1 : SAMPLE_MAX_CYC_RAW;
  localparam int         FILT_CYC           = 8;

  // AXI responses.
  localparam logic [1:0] RESP_OKAY          = 2'h0;
  localparam logic [1:0] RESP_SLVERR        = 2'h2;
endpackage

/* hw/wcs_clk_divider.sv */
// Programmable clock output divider: divides the input clock by the programmed ratio.
`timescale 1ns/1ps
module wcs_clk_divider (
  input  wire logic       aclk,
  input  wire logic       aresetn,
  input  wire logic [7:0] ratio,
  output logic            clk_div_out
);
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  logic       next_out;

  // Counts ratio cycles; output high for the first ratio/2 cycles, rounded down, of each period.
  always_comb begin
    if (cnt >= ratio - 8'h01) begin
      next_cnt = 8'h00;
    end else begin
      next_cnt = cnt + 8'h01;
    end
    next_out = (next_cnt < (ratio >> 1));
  end

  // Registers counter and output.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cnt         <= 8'h00;
      clk_div_out <= 1'b0;
    end else begin
      cnt         <= next_cnt;
      clk_div_out <= next_out;
    end
  end
endmodule

/* hw/wcs_regs.sv */
// Card-sense threshold register bank with AXI4-Lite slave and detection evaluation.
//
// The implementer's own choice: the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
// Functional notes
// - Eight-bit read/write output divider ratio register.
// - Ratios 8 to 254 divide exactly; 0-7 reserved.
// - I upper limit assembled from three registers.
// - I above upper limit sets detect flag.
// - Q above lower limit sets detect flag.
// - Q above upper limit sets detect flag.
// - I below lower limit sets detect flag.
// - Last I measurement readable, upper bits reserved.
// - Last Q measurement readable in low bits.
// - Suppress bit blocks flag until next detection.
// - Options register present only when revision allows.
// - Options: swing, filter, two unsettled flags.
// - Filter enabled uses filtered values, bounded time; no time limit here, the filter averages every sample until detect_end.
// - With filter enabled, unsettled flags show channel changed while measuring.
module wcs_regs #(
  parameter bit HAS_OPTIONS = 1'b1
) (
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [9:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [9:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        detect_start,
  input  wire logic        sample_valid,
  input  wire logic [5:0]  i_sample,
  input  wire logic [5:0]  q_sample,
  input  wire logic        detect_end,
  output logic             detect_irq_flag,
  output logic             tx_full_swing,
  output logic             clk_div_out
);
  // ---------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------
  logic [7:0] output_divider_ratio, next_divider;
  logic [7:0] q_lower_reg, next_q_lower;
  logic [7:0] q_upper_reg, next_q_upper;
  logic [7:0] i_lower_reg, next_i_lower;
  logic [5:0] i_last_sample, next_i_last;
  logic [5:0] q_last_sample, next_q_last;
  logic       detect_irq_suppress, next_suppress;
  logic       tx_swing_bit, next_tx_swing;
  logic       noise_filter_enable, next_filter;
  logic       i_unsettled_flag, next_i_uns;
  logic       q_unsettled_flag, next_q_uns;
  logic       next_flag;
  logic [5:0] i_filt, next_i_filt, q_filt, next_q_filt;
  logic [5:0] i_first, next_i_first, q_first, next_q_first;
  logic       i_moved, next_i_moved, q_moved, next_q_moved;
  logic       have_first, next_have_first;
  logic [5:0] i_upper_limit;
  logic [5:0] i_eval, q_eval;
  logic       hit;

  // ---------------------------------------------------------------
  // AXI4-Lite handshake state
  // ---------------------------------------------------------------
  logic       aw_held, next_aw_held, w_held, next_w_held;
  logic [7:0] aw_idx, next_aw_idx;
  logic [31:0] w_data, next_w_data;
  logic [3:0] w_strb, next_w_strb;
  logic       next_bvalid;
  logic [1:0] next_bresp;
  logic       next_rvalid;
  logic [1:0] next_rresp;
  logic [31:0] next_rdata;
  logic       do_write, wr_ok;
  logic [7:0] rd_idx;
  logic [7:0] rd_byte;

  // Address and data are accepted independently, one write at a time.
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign s_axi_arready = !s_axi_rvalid;
  assign do_write      = (aw_held || (s_axi_awvalid && s_axi_awready)) &&
                         (w_held || (s_axi_wvalid && s_axi_wready)) && !s_axi_bvalid;
  assign rd_idx        = s_axi_araddr[9:2];

  // Decodes whether an index is a mapped register.
  function automatic logic mapped(input logic [7:0] idx);
    mapped = (idx == wcs_pkg::IDX_CLK_OUT_DIV) || (idx == wcs_pkg::IDX_Q_LOWER) ||
             (idx == wcs_pkg::IDX_Q_UPPER) || (idx == wcs_pkg::IDX_I_LOWER) ||
             (idx == wcs_pkg::IDX_I_LAST) || (idx == wcs_pkg::IDX_Q_LAST) ||
             (idx == wcs_pkg::IDX_DETECT_STATUS) ||
             (HAS_OPTIONS && (idx == wcs_pkg::IDX_DETECT_OPTIONS));
  endfunction

  // Read data multiplexer.
  always_comb begin
    rd_byte = 8'h00;
    case (rd_idx)
      wcs_pkg::IDX_CLK_OUT_DIV: rd_byte = output_divider_ratio;
      wcs_pkg::IDX_Q_LOWER:     rd_byte = q_lower_reg;
      wcs_pkg::IDX_Q_UPPER:     rd_byte = q_upper_reg;
      wcs_pkg::IDX_I_LOWER:     rd_byte = i_lower_reg;
      wcs_pkg::IDX_I_LAST:      rd_byte = {2'h0, i_last_sample};
      wcs_pkg::IDX_Q_LAST:      rd_byte = {1'b0, detect_irq_suppress, q_last_sample};
      wcs_pkg::IDX_DETECT_STATUS: rd_byte = {7'h00, detect_irq_flag};
      wcs_pkg::IDX_DETECT_OPTIONS: rd_byte = HAS_OPTIONS ?
        {4'h0, tx_swing_bit, noise_filter_enable, q_unsettled_flag, i_unsettled_flag} : 8'h00;
      default: rd_byte = 8'h00;
    endcase
  end

  // Write and read channel next state.
  always_comb begin
    next_aw_held = aw_held;
    next_aw_idx  = aw_idx;
    next_w_held  = w_held;
    next_w_data  = w_data;
    next_w_strb  = w_strb;
    next_bvalid  = s_axi_bvalid;
    next_bresp   = s_axi_bresp;
    next_rvalid  = s_axi_rvalid;
    next_rresp   = s_axi_rresp;
    next_rdata   = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_idx  = s_axi_awaddr[9:2];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    if (do_write) begin
      next_aw_held = 1'b0;
      next_w_held  = 1'b0;
      next_bvalid  = 1'b1;
      next_bresp   = mapped(next_aw_idx) ? wcs_pkg::RESP_OKAY : wcs_pkg::RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      next_rdata  = {24'h000000, rd_byte};
      next_rresp  = mapped(rd_idx) ? wcs_pkg::RESP_OKAY : wcs_pkg::RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  assign wr_ok = do_write && next_w_strb[0];

  // ---------------------------------------------------------------
  // Detection evaluation
  // ---------------------------------------------------------------
  // assemble upper limit
  assign i_upper_limit = {q_lower_reg[7:6], q_upper_reg[7:6], i_lower_reg[7:6]};
  assign i_eval = noise_filter_enable ? i_filt : i_sample;
  assign q_eval = noise_filter_enable ? q_filt : q_sample;
  assign hit = (i_eval > i_upper_limit) || (q_eval > q_lower_reg[5:0]) ||
               (q_eval > q_upper_reg[5:0]) || (i_eval < i_lower_reg[5:0]);

  // Register writes, filter tracking and detection result.
  always_comb begin
    next_divider    = output_divider_ratio;
    next_q_lower    = q_lower_reg;
    next_q_upper    = q_upper_reg;
    next_i_lower    = i_lower_reg;
    next_suppress   = detect_irq_suppress;
    next_tx_swing   = tx_swing_bit;
    next_filter     = noise_filter_enable;
    next_i_last     = i_last_sample;
    next_q_last     = q_last_sample;
    next_i_uns      = i_unsettled_flag;
    next_q_uns      = q_unsettled_flag;
    next_flag       = detect_irq_flag;
    next_i_filt     = i_filt;
    next_q_filt     = q_filt;
    next_i_first    = i_first;
    next_q_first    = q_first;
    next_i_moved    = i_moved;
    next_q_moved    = q_moved;
    next_have_first = have_first;
    if (wr_ok) begin
      case (next_aw_idx)
        wcs_pkg::IDX_CLK_OUT_DIV: next_divider = next_w_data[7:0];
        wcs_pkg::IDX_Q_LOWER:     next_q_lower = next_w_data[7:0];
        wcs_pkg::IDX_Q_UPPER:     next_q_upper = next_w_data[7:0];
        wcs_pkg::IDX_I_LOWER:     next_i_lower = next_w_data[7:0];
        wcs_pkg::IDX_Q_LAST:      next_suppress = next_w_data[wcs_pkg::QRES_SUPPRESS];
        // Writing one clears the sticky flag.
        wcs_pkg::IDX_DETECT_STATUS: next_flag = detect_irq_flag & ~next_w_data[0];
        wcs_pkg::IDX_DETECT_OPTIONS: begin
          if (HAS_OPTIONS) begin
            next_tx_swing = next_w_data[wcs_pkg::OPT_TX_FULL_SWING];
            next_filter   = next_w_data[wcs_pkg::OPT_NOISE_FILTER];
          end
        end
        default: begin
        end
      endcase
    end
    if (detect_start) begin
      next_suppress   = 1'b0;
      next_have_first = 1'b0;
      next_i_moved    = 1'b0;
      next_q_moved    = 1'b0;
    end
    if (sample_valid) begin
      next_have_first = 1'b1;
      next_i_filt = have_first ? 6'((7'(i_filt) + 7'(i_sample)) >> 1) : i_sample;
      next_q_filt = have_first ? 6'((7'(q_filt) + 7'(q_sample)) >> 1) : q_sample;
      if (!have_first) begin
        next_i_first = i_sample;
        next_q_first = q_sample;
      end else begin
        next_i_moved = i_moved | (i_sample != i_first);
        next_q_moved = q_moved | (q_sample != q_first);
      end
    end
    if (detect_end) begin
      next_i_last = i_eval;
      next_q_last = q_eval;
      next_i_uns  = noise_filter_enable & i_moved;
      next_q_uns  = noise_filter_enable & q_moved;
      if (hit && !detect_irq_suppress) begin
        next_flag = 1'b1;
      end
    end
  end

  // Registers all state.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_idx <= 8'h00;
      w_held <= 1'b0;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h00000000;
      output_divider_ratio <= wcs_pkg::RST_DIVIDER;
      q_lower_reg <= wcs_pkg::RST_LIMIT;
      q_upper_reg <= wcs_pkg::RST_LIMIT;
      i_lower_reg <= wcs_pkg::RST_LIMIT;
      i_last_sample <= 6'h00;
      q_last_sample <= 6'h00;
      detect_irq_suppress <= 1'b0;
      tx_swing_bit <= 1'b0;
      noise_filter_enable <= 1'b0;
      i_unsettled_flag <= 1'b0;
      q_unsettled_flag <= 1'b0;
      detect_irq_flag <= 1'b0;
      i_filt <= 6'h00;
      q_filt <= 6'h00;
      i_first <= 6'h00;
      q_first <= 6'h00;
      i_moved <= 1'b0;
      q_moved <= 1'b0;
      have_first <= 1'b0;
    end else begin
      aw_held <= next_aw_held & ~do_write;
      aw_idx <= next_aw_idx;
      w_held <= next_w_held & ~do_write;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
      s_axi_rvalid <= next_rvalid;
      s_axi_rresp <= next_rresp;
      s_axi_rdata <= next_rdata;
      output_divider_ratio <= next_divider;
      q_lower_reg <= next_q_lower;
      q_upper_reg <= next_q_upper;
      i_lower_reg <= next_i_lower;
      i_last_sample <= next_i_last;
      q_last_sample <= next_q_last;
      detect_irq_suppress <= next_suppress;
      tx_swing_bit <= next_tx_swing;
      noise_filter_enable <= next_filter;
      i_unsettled_flag <= next_i_uns;
      q_unsettled_flag <= next_q_uns;
      detect_irq_flag <= next_flag;
      i_filt <= next_i_filt;
      q_filt <= next_q_filt;
      i_first <= next_i_first;
      q_first <= next_q_first;
      i_moved <= next_i_moved;
      q_moved <= next_q_moved;
      have_first <= next_have_first;
    end
  end

  assign tx_full_swing = tx_swing_bit;

  wcs_clk_divider i_wcs_clk_divider (
    .aclk        (aclk),
    .aresetn     (aresetn),
    .ratio       (output_divider_ratio),
    .clk_div_out (clk_div_out)
  );
endmodule

/* verif/wcs_regs_asserts.sv */
// Concurrent checks on the ports of the card-sense register bank.
`timescale 1ns/1ps
module wcs_regs_asserts (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        detect_end,
  input wire logic        detect_irq_flag,
  input wire logic        tx_full_swing,
  input wire logic        clk_div_out
);
  // ---------------------------------------------------------------
  // Bus, detection and output checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Responses are idle and the flag is clear on the first edge after reset.
  a_reset_quiet: assert property ($rose(aresetn) |-> !s_axi_bvalid && !s_axi_rvalid
    && !detect_irq_flag) else $error("outputs not idle after reset");
  // A taken read address is answered on the next edge.
  a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered in one cycle");
  // Address and data taken together are answered on the next edge.
  a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
    && s_axi_wready |=> s_axi_bvalid) else $error("write not answered in one cycle");
  // Read data stands unchanged until the master takes it.
  a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
    && $stable(s_axi_rdata)) else $error("read data dropped before taken");
  // Write response stands unchanged until the master takes it.
  a_bresp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
    && $stable(s_axi_bresp)) else $error("write response dropped before taken");
  // The flag only rises after an evaluation pulse.
  a_flag_at_end: assert property ($rose(detect_irq_flag) |-> $past(detect_end))
    else $error("flag rose without evaluation");
  // With no write under way the flag stays set.
  a_flag_sticky: assert property (detect_irq_flag && !s_axi_wvalid && !s_axi_awvalid
    |=> detect_irq_flag) else $error("flag cleared without a write");
  // A high phase of the divided clock ends within the largest ratio.
  a_div_live: assert property ($rose(clk_div_out) |-> ##[1:254] $fell(clk_div_out))
    else $error("divided clock stuck high");
  // The swing output changes only as the result of a register write.
  a_swing_write: assert property ($changed(tx_full_swing)
    |-> $past(s_axi_wvalid || s_axi_awvalid)) else $error("swing changed without write");
endmodule

bind wcs_regs wcs_regs_asserts i_wcs_regs_asserts (
  .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .detect_end(detect_end),
  .detect_irq_flag(detect_irq_flag), .tx_full_swing(tx_full_swing),
  .clk_div_out(clk_div_out)
);

/* verif/wcs_regs_tb.sv */
// Self-checking bench for the card-sense register bank.
`timescale 1ns/1ps
module wcs_regs_tb;
  // ---------------------------------------------------------------
  // Signals and constants
  // ---------------------------------------------------------------
  localparam logic [1:0] OK = wcs_pkg::RESP_OKAY;
  localparam logic [1:0] ER = wcs_pkg::RESP_SLVERR;
  logic        aclk = 1'h0;
  logic        aresetn = 1'h0;
  logic [9:0]  awaddr = '0;
  logic [9:0]  araddr = '0;
  logic [31:0] wdata = '0;
  logic        awvalid = 1'h0;
  logic        wvalid = 1'h0;
  logic        bready = 1'h0;
  logic        arvalid = 1'h0;
  logic        rready = 1'h0;
  logic        dstart = 1'h0;
  logic        sval = 1'h0;
  logic        dend = 1'h0;
  logic [5:0]  isamp = '0;
  logic [5:0]  qsamp = '0;
  logic        awready, wready, bvalid, arready, rvalid, flag, tx, cdiv;
  logic [1:0]  bresp, rresp;
  logic [31:0] rdata;
  int          fail_count = 0;
  int          total_checks = 0;
  // Detection table: q lower, q upper, i lower registers, i, q, expected flag.
  logic [47:0] tbl [8] = '{48'hBF_FF_45_2D_10_00, 48'hBF_FF_45_2E_10_01,
    48'hBF_FF_45_05_10_00, 48'hBF_FF_45_04_10_01, 48'hBF_E0_45_10_20_00,
    48'hBF_E0_45_10_21_01, 48'h90_FF_45_10_10_00, 48'h90_FF_45_10_11_01};

  // Clock of 10 ns period.
  always #5 aclk = ~aclk;

  // Device under test.
  wcs_regs i_wcs_regs (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .detect_start(dstart), .sample_valid(sval), .i_sample(isamp), .q_sample(qsamp),
    .detect_end(dend), .detect_irq_flag(flag), .tx_full_swing(tx), .clk_div_out(cdiv)
  );

  // ---------------------------------------------------------------
  // Bus and compare tasks
  // ---------------------------------------------------------------
  // Compares one value and counts the outcome.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // Writes one register byte and checks the response code.
  task automatic wr(input logic [7:0] ix, input logic [7:0] d, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    awaddr <= {ix, 2'h0};
    wdata <= {24'h0, d};
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
    end while (bvalid !== 1'h1 && n < 100);
    if (n >= 100) fail_count++;
    bready <= 1'h0;
    chk(32'(bresp), 32'(er));
  endtask

  // Reads one register and checks data and response code.
  task automatic rd(input logic [7:0] ix, input logic [7:0] e, input logic [1:0] er);
    int n;
    n = 0;
    @(posedge aclk);
    araddr <= {ix, 2'h0};
    arvalid <= 1'h1;
    rready <= 1'h1;
    do begin
      @(posedge aclk);
      n++;
      if (arready) arvalid <= 1'h0;
    end while (rvalid !== 1'h1 && n < 100);
    if (n >= 100) fail_count++;
    rready <= 1'h0;
    chk(rdata, {24'h0, e});
    chk(32'(rresp), 32'(er));
  endtask

  // Runs one detection; sup sets suppress mid-run, vary disturbs the first q sample.
  task automatic det(input logic [5:0] i, input logic [5:0] q, input bit sup, input bit vary);
    @(posedge aclk);
    dstart <= 1'h1;
    @(posedge aclk);
    dstart <= 1'h0;
    if (sup) wr(wcs_pkg::IDX_Q_LAST, 8'h40, OK);
    @(posedge aclk);
    sval <= 1'h1;
    isamp <= i;
    qsamp <= q ^ {5'h0, vary};
    @(posedge aclk);
    qsamp <= q;
    @(posedge aclk);
    sval <= 1'h0;
    dend <= 1'h1;
    @(posedge aclk);
    dend <= 1'h0;
    isamp <= ~i;
    qsamp <= ~q;
    repeat (2) @(posedge aclk);
  endtask

  // Programs a ratio and measures one full period of the divided clock.
  task automatic divp(input logic [7:0] r);
    int c, k, n;
    logic p;
    c = 0;
    k = 0;
    n = 0;
    wr(wcs_pkg::IDX_CLK_OUT_DIV, r, OK);
    p = cdiv;
    repeat (4 * r) begin
      @(posedge aclk);
      c++;
      if (cdiv && !p) begin
        k++;
        if (k == 3) n = c;
        c = 0;
      end
      p = cdiv;
    end
    chk(32'(n), {24'h0, r});
  endtask

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  // Reset values, access kinds and an unmapped index.
  task automatic t_regs();
    rd(wcs_pkg::IDX_CLK_OUT_DIV, wcs_pkg::RST_DIVIDER, OK);
    rd(wcs_pkg::IDX_Q_LOWER, 8'h00, OK);
    rd(wcs_pkg::IDX_DETECT_OPTIONS, 8'h00, OK);
    wr(wcs_pkg::IDX_CLK_OUT_DIV, 8'hFE, OK);
    rd(wcs_pkg::IDX_CLK_OUT_DIV, 8'hFE, OK);
    wr(wcs_pkg::IDX_DETECT_OPTIONS, 8'hFF, OK);
    rd(wcs_pkg::IDX_DETECT_OPTIONS, 8'h0C, OK);
    chk(32'(tx), 32'h1);
    wr(wcs_pkg::IDX_DETECT_OPTIONS, 8'h00, OK);
    chk(32'(tx), 32'h0);
    wr(wcs_pkg::IDX_I_LAST, 8'hFF, OK);
    rd(wcs_pkg::IDX_I_LAST, 8'h00, OK);
    wr(8'h3B, 8'h55, ER);
    rd(8'h3B, 8'h00, ER);
  endtask

  // Every limit on both sides of its boundary, with results read back.
  task automatic t_detect();
    foreach (tbl[k]) begin
      wr(wcs_pkg::IDX_Q_LOWER, tbl[k][47:40], OK);
      wr(wcs_pkg::IDX_Q_UPPER, tbl[k][39:32], OK);
      wr(wcs_pkg::IDX_I_LOWER, tbl[k][31:24], OK);
      wr(wcs_pkg::IDX_DETECT_STATUS, 8'h01, OK);
      rd(wcs_pkg::IDX_Q_UPPER, tbl[k][39:32], OK);
      det(tbl[k][21:16], tbl[k][13:8], 1'b0, 1'b0);
      chk(32'(flag), {24'h0, tbl[k][7:0]});
      rd(wcs_pkg::IDX_I_LAST, {2'h0, tbl[k][21:16]}, OK);
      rd(wcs_pkg::IDX_Q_LAST, {2'h0, tbl[k][13:8]}, OK);
    end
  endtask

  // Suppress set mid-detection blocks the flag; the next detection raises it.
  task automatic t_supp();
    wr(wcs_pkg::IDX_DETECT_STATUS, 8'h01, OK);
    det(6'h11, 6'h11, 1'b1, 1'b0);
    chk(32'(flag), 32'h0);
    rd(wcs_pkg::IDX_Q_LAST, 8'h51, OK);
    det(6'h11, 6'h11, 1'b0, 1'b0);
    chk(32'(flag), 32'h1);
  endtask

  // With the filter on, only the disturbed q channel reports unsettled.
  task automatic t_filt();
    wr(wcs_pkg::IDX_DETECT_OPTIONS, 8'h04, OK);
    det(6'h10, 6'h10, 1'b0, 1'b1);
    rd(wcs_pkg::IDX_DETECT_OPTIONS, 8'h06, OK);
    det(6'h10, 6'h10, 1'b0, 1'b0);
    rd(wcs_pkg::IDX_DETECT_OPTIONS, 8'h04, OK);
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Main sequence after five reset cycles.
  initial begin
    repeat (5) @(posedge aclk);
    aresetn <= 1'h1;
    t_regs();
    divp(8'h08);
    divp(8'h09);
    divp(8'hFE);
    t_detect();
    t_supp();
    t_filt();
    end_sim();
  end

  // Watchdog well beyond the expected run length.
  initial begin
    #200000;
    fail_count++;
    end_sim();
  end
endmodule
